// file: hdl/pc_stack_core.sv
`timescale 1ns/10ps
module pc_stack_core (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// instruction sequencer
	input wire logic seq_step,
	input wire logic seq_call,
	input wire logic seq_goto,
	input wire logic seq_int,
	input wire logic seq_ret,
	input wire logic [pcs_pkg::TGT_W-1:0] seq_target,
	output logic [pcs_pkg::PC_W-1:0] fetch_addr,
	// data memory, read data valid the cycle after mem_re
	output logic [pcs_pkg::DA_W-1:0] mem_addr,
	output logic mem_we,
	output logic mem_re,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	// axi4-lite register slave
	input wire logic [pcs_pkg::AXA_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [pcs_pkg::AXA_W-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);
	regbus_if rb ();
	stack_if stk ();

	logic [pcs_pkg::PC_W-1:0] pc_d;
	logic [pcs_pkg::HI_W-1:0] latch_q, latch_d;
	logic [7:0] ptr_q, ptr_d;
	logic bank_q, bank_d;
	logic [pcs_pkg::DA_W-1:0] mem_addr_d;
	logic mem_we_d, mem_re_d;
	logic [7:0] mem_wdata_d;
	logic [1:0] rd_wait_q, rd_wait_d;
	logic done_d, err_d;
	logic [31:0] rdata_d;
	logic lane0, low_wr, ind_self;
	logic [pcs_pkg::DA_W-1:0] ind_addr;

	axil_slave u_bus (
		.clock(clock),
		.sys_rst(sys_rst),
		.awaddr(s_awaddr),
		.awvalid(s_awvalid),
		.awready(s_awready),
		.wdata(s_wdata),
		.wstrb(s_wstrb),
		.wvalid(s_wvalid),
		.wready(s_wready),
		.bresp(s_bresp),
		.bvalid(s_bvalid),
		.bready(s_bready),
		.araddr(s_araddr),
		.arvalid(s_arvalid),
		.arready(s_arready),
		.rdata(s_rdata),
		.rresp(s_rresp),
		.rvalid(s_rvalid),
		.rready(s_rready),
		.rb(rb)
	);

	return_stack u_stack (
		.clock(clock),
		.sys_rst(sys_rst),
		.stk(stk)
	);

	// only byte lane 0 carries register data
	assign lane0 = rb.strb[0];
	assign low_wr = rb.wr_req && rb.addr == pcs_pkg::REG_PC_LOW && lane0;
	assign ind_self = ptr_q == pcs_pkg::PTR_SELF;
	assign ind_addr = {bank_q & pcs_pkg::BANK_EN, ptr_q};

	// program counter: a software write of the low byte outranks sequencer events
	always_comb begin
		pc_d = fetch_addr;
		stk.push = 1'b0;
		stk.pop = 1'b0;
		stk.push_pc = fetch_addr;
		if (low_wr) begin
			pc_d = {latch_q, rb.wdata[7:0]};
		end else if (seq_int) begin
			stk.push = 1'b1;
			pc_d = pcs_pkg::IRQ_VEC;
		end else if (seq_call) begin
			stk.push = 1'b1;
			pc_d = {latch_q[pcs_pkg::HI_W-1:pcs_pkg::PAGE_LO], seq_target};
		end else if (seq_goto) begin
			pc_d = {latch_q[pcs_pkg::HI_W-1:pcs_pkg::PAGE_LO], seq_target};
		end else if (seq_ret) begin
			stk.pop = 1'b1;
			pc_d = stk.top_pc;
		end else if (seq_step) begin
			pc_d = fetch_addr + pcs_pkg::PC_ONE;
		end
	end

	// software registers and the indirect port; the latch never follows stack traffic
	always_comb begin
		latch_d = latch_q;
		ptr_d = ptr_q;
		bank_d = bank_q;
		mem_addr_d = mem_addr;
		mem_we_d = 1'b0;
		mem_re_d = 1'b0;
		mem_wdata_d = mem_wdata;
		rd_wait_d = {rd_wait_q[0], 1'b0};
		done_d = 1'b0;
		err_d = 1'b0;
		rdata_d = rb.rdata;
		if (rb.wr_req) begin
			done_d = 1'b1;
			case (rb.addr)
				pcs_pkg::REG_INDIRECT: begin
					if (lane0 && !ind_self) begin
						mem_we_d = 1'b1;
						mem_addr_d = ind_addr;
						mem_wdata_d = rb.wdata[7:0];
					end
				end
				pcs_pkg::REG_PC_LOW: ;
				pcs_pkg::REG_STATUS: begin
					if (lane0) begin
						bank_d = rb.wdata[pcs_pkg::BANK_BIT];
					end
				end
				pcs_pkg::REG_POINTER: begin
					if (lane0) begin
						ptr_d = rb.wdata[7:0];
					end
				end
				pcs_pkg::REG_LATCH: begin
					if (lane0) begin
						latch_d = rb.wdata[pcs_pkg::HI_W-1:0];
					end
				end
				default: err_d = 1'b1;
			endcase
		end else if (rb.rd_req) begin
			done_d = 1'b1;
			rdata_d = '0;
			case (rb.addr)
				pcs_pkg::REG_INDIRECT: begin
					if (!ind_self) begin
						done_d = 1'b0;
						mem_re_d = 1'b1;
						mem_addr_d = ind_addr;
						rd_wait_d = {rd_wait_q[0], 1'b1};
					end
				end
				pcs_pkg::REG_PC_LOW: rdata_d[7:0] = fetch_addr[7:0];
				pcs_pkg::REG_STATUS: rdata_d[pcs_pkg::BANK_BIT] = bank_q;
				pcs_pkg::REG_POINTER: rdata_d[7:0] = ptr_q;
				pcs_pkg::REG_LATCH: rdata_d[pcs_pkg::HI_W-1:0] = latch_q;
				default: err_d = 1'b1;
			endcase
		end
		if (rd_wait_q[1]) begin
			done_d = 1'b1;
			rdata_d = {24'h00_0000, mem_rdata};
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fetch_addr <= pcs_pkg::PC_RST;
			latch_q <= pcs_pkg::LATCH_RST;
			ptr_q <= pcs_pkg::PTR_RST;
			bank_q <= 1'b0;
			mem_addr <= '0;
			mem_we <= 1'b0;
			mem_re <= 1'b0;
			mem_wdata <= 8'h00;
			rd_wait_q <= 2'h0;
			rb.done <= 1'b0;
			rb.err <= 1'b0;
			rb.rdata <= 32'h0000_0000;
		end else begin
			fetch_addr <= pc_d;
			latch_q <= latch_d;
			ptr_q <= ptr_d;
			bank_q <= bank_d;
			mem_addr <= mem_addr_d;
			mem_we <= mem_we_d;
			mem_re <= mem_re_d;
			mem_wdata <= mem_wdata_d;
			rd_wait_q <= rd_wait_d;
			rb.done <= done_d;
			rb.err <= err_d;
			rb.rdata <= rdata_d;
		end
	end

	low_write_load_a: assert property (@(posedge clock) disable iff (sys_rst)
		low_wr |=> fetch_addr == {$past(latch_q), $past(rb.wdata[7:0])})
		else $error("low byte write did not load upper bits from latch");

	call_target_a: assert property (@(posedge clock) disable iff (sys_rst)
		(seq_call || seq_goto) && !low_wr && !seq_int
		|=> fetch_addr[pcs_pkg::TGT_W-1:0] == $past(seq_target)
		&& fetch_addr[pcs_pkg::TGT_W] == $past(latch_q[pcs_pkg::PAGE_LO]))
		else $error("branch target or page bit wrong");

	int_push_a: assert property (@(posedge clock) disable iff (sys_rst)
		seq_int && !low_wr |-> stk.push && stk.push_pc == fetch_addr
		##1 fetch_addr == pcs_pkg::IRQ_VEC)
		else $error("interrupt did not push and vector");

	latch_stable_a: assert property (@(posedge clock) disable iff (sys_rst)
		(stk.push || stk.pop) && !rb.wr_req |=> $stable(latch_q))
		else $error("stack traffic changed the high latch");

	ret_restore_a: assert property (@(posedge clock) disable iff (sys_rst)
		stk.pop |=> fetch_addr == $past(stk.top_pc))
		else $error("return did not restore popped address");

	self_read_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
		rb.rd_req && rb.addr == pcs_pkg::REG_INDIRECT && ind_self
		|=> rb.done && rb.rdata == 32'h0000_0000 && !mem_re)
		else $error("self-indirect read not zero");

	self_write_nop_a: assert property (@(posedge clock) disable iff (sys_rst)
		rb.wr_req && rb.addr == pcs_pkg::REG_INDIRECT && ind_self
		|=> !mem_we && $stable(ptr_q) && $stable(latch_q))
		else $error("self-indirect write was not a no-op");

	indirect_route_a: assert property (@(posedge clock) disable iff (sys_rst)
		rb.rd_req && rb.addr == pcs_pkg::REG_INDIRECT && !ind_self
		|=> mem_re && mem_addr == {1'b0, $past(ptr_q)} ##2 rb.done)
		else $error("indirect read not routed through pointer");

	step_inc_a: assert property (@(posedge clock) disable iff (sys_rst)
		seq_step && !seq_int && !seq_call && !seq_goto && !seq_ret && !low_wr
		|=> fetch_addr == $past(fetch_addr) + pcs_pkg::PC_ONE)
		else $error("step did not advance the counter by one");

	pc_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		!(seq_step || seq_call || seq_goto || seq_int || seq_ret || low_wr)
		|=> $stable(fetch_addr))
		else $error("counter moved without an event or low byte write");

	call_push_a: assert property (@(posedge clock) disable iff (sys_rst)
		seq_call && !seq_int && !low_wr
		|-> stk.push && stk.push_pc == fetch_addr)
		else $error("call did not push the counter");

	goto_no_push_a: assert property (@(posedge clock) disable iff (sys_rst)
		seq_goto && !seq_call && !seq_int && !low_wr
		|-> !stk.push && !stk.pop)
		else $error("goto touched the return stack");

	ret_pop_a: assert property (@(posedge clock) disable iff (sys_rst)
		seq_ret && !seq_goto && !seq_call && !seq_int && !low_wr
		|-> stk.pop && !stk.push)
		else $error("return did not pop the stack");

	bank_unused_a: assert property (@(posedge clock) disable iff (sys_rst)
		mem_re || mem_we |-> !mem_addr[pcs_pkg::DA_W-1])
		else $error("bank bit reached the data address");

	low_read_a: assert property (@(posedge clock) disable iff (sys_rst)
		rb.rd_req && rb.addr == pcs_pkg::REG_PC_LOW
		|=> rb.done && rb.rdata == {24'h00_0000, $past(fetch_addr[7:0])})
		else $error("low byte read did not return the counter");

	indirect_write_a: assert property (@(posedge clock) disable iff (sys_rst)
		rb.wr_req && rb.addr == pcs_pkg::REG_INDIRECT && lane0 && !ind_self
		|=> mem_we && mem_addr == {1'b0, $past(ptr_q)}
		&& mem_wdata == $past(rb.wdata[7:0]))
		else $error("indirect write not routed through pointer");
endmodule // pc_stack_core

// file: hdl/pcs_pkg.sv
package pcs_pkg;
	localparam int PC_W = 13;
	localparam int HI_W = 5;
	localparam int TGT_W = 11;
	localparam int STK_N = 8;
	localparam int SP_W = 3;
	localparam int DA_W = 9;
	localparam int AXA_W = 8;
	localparam int PAGE_LO = 3;
	localparam int BANK_BIT = 7;
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	localparam logic [PC_W-1:0] IRQ_VEC = 13'h0004;
	localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
	localparam logic [SP_W-1:0] SP_ONE = 3'h1;
	localparam logic [SP_W-1:0] SP_LAST = 3'h7;
	localparam logic [HI_W-1:0] LATCH_RST = 5'h00;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] PTR_SELF = 8'h00;
	// bank bit is stored but not used for addressing on this device
	localparam logic BANK_EN = 1'b0;
	localparam logic [AXA_W-1:0] REG_INDIRECT = 8'h00;
	localparam logic [AXA_W-1:0] REG_PC_LOW = 8'h04;
	localparam logic [AXA_W-1:0] REG_STATUS = 8'h08;
	localparam logic [AXA_W-1:0] REG_POINTER = 8'h0C;
	localparam logic [AXA_W-1:0] REG_LATCH = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {S_IDLE, S_WACT, S_WRESP, S_RACT, S_RRESP} bus_state_e;
endpackage

// file: hdl/pcs_links.sv
`timescale 1ns/10ps
interface stack_if;
	logic push;
	logic pop;
	logic [pcs_pkg::PC_W-1:0] push_pc;
	logic [pcs_pkg::PC_W-1:0] top_pc;
	modport owner (input push, input pop, input push_pc, output top_pc);
	modport user (output push, output pop, output push_pc, input top_pc);
endinterface

interface regbus_if;
	logic wr_req;
	logic rd_req;
	logic [pcs_pkg::AXA_W-1:0] addr;
	logic [31:0] wdata;
	logic [3:0] strb;
	logic done;
	logic err;
	logic [31:0] rdata;
	modport bus (output wr_req, output rd_req, output addr, output wdata, output strb,
		input done, input err, input rdata);
	modport core (input wr_req, input rd_req, input addr, input wdata, input strb,
		output done, output err, output rdata);
endinterface

// file: hdl/return_stack.sv
`timescale 1ns/10ps
module return_stack (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// push and pop from the sequencer side
	stack_if.owner stk
);
	logic [pcs_pkg::PC_W-1:0] mem_q [pcs_pkg::STK_N];
	logic [pcs_pkg::PC_W-1:0] mem_d [pcs_pkg::STK_N];
	logic [pcs_pkg::SP_W-1:0] sp_q;
	logic [pcs_pkg::SP_W-1:0] sp_d;

	// pointer wraps freely: no overflow or underflow flag exists
	always_comb begin
		mem_d = mem_q;
		sp_d = sp_q;
		if (stk.push) begin
			mem_d[sp_q] = stk.push_pc;
			sp_d = sp_q + pcs_pkg::SP_ONE;
		end else if (stk.pop) begin
			sp_d = sp_q - pcs_pkg::SP_ONE;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sp_q <= '0;
			for (int i = 0; i < pcs_pkg::STK_N; i++) begin
				mem_q[i] <= pcs_pkg::PC_RST;
			end
		end else begin
			sp_q <= sp_d;
			mem_q <= mem_d;
		end
	end

	assign stk.top_pc = mem_q[sp_q - pcs_pkg::SP_ONE];

	ptr_wrap_a: assert property (@(posedge clock) disable iff (sys_rst)
		stk.push && sp_q == pcs_pkg::SP_LAST |=> sp_q == '0)
		else $error("stack pointer did not wrap after eighth entry");

	lifo_return_a: assert property (@(posedge clock) disable iff (sys_rst)
		stk.push ##1 (stk.pop && !stk.push) |-> stk.top_pc == $past(stk.push_pc))
		else $error("pop did not return last pushed address");
endmodule // return_stack

// file: hdl/axil_slave.sv
`timescale 1ns/10ps
module axil_slave (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// write address and data
	input wire logic [pcs_pkg::AXA_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address and data
	input wire logic [pcs_pkg::AXA_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register requests toward the core
	regbus_if.bus rb
);
	pcs_pkg::bus_state_e st_q, st_d;
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [pcs_pkg::AXA_W-1:0] waddr_q, waddr_d, addr_q, addr_d;
	logic [31:0] wbuf_q, wbuf_d, rdata_d;
	logic [3:0] strb_q, strb_d;
	logic wr_req_d, rd_req_d, bvalid_d, rvalid_d;
	logic awready_d, wready_d, arready_d;
	logic [1:0] bresp_d, rresp_d;

	always_comb begin
		st_d = st_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		waddr_d = waddr_q;
		addr_d = addr_q;
		wbuf_d = wbuf_q;
		strb_d = strb_q;
		wr_req_d = 1'b0;
		rd_req_d = 1'b0;
		bvalid_d = bvalid;
		rvalid_d = rvalid;
		bresp_d = bresp;
		rresp_d = rresp;
		rdata_d = rdata;
		case (st_q)
			pcs_pkg::S_IDLE: begin
				if (awvalid && awready) begin
					aw_have_d = 1'b1;
					waddr_d = awaddr;
				end
				if (wvalid && wready) begin
					w_have_d = 1'b1;
					wbuf_d = wdata;
					strb_d = wstrb;
				end
				// reads only start with no write half held, so a write never starves
				if (arvalid && arready) begin
					addr_d = araddr;
					rd_req_d = 1'b1;
					st_d = pcs_pkg::S_RACT;
				end else if (aw_have_d && w_have_d) begin
					addr_d = waddr_d;
					aw_have_d = 1'b0;
					w_have_d = 1'b0;
					wr_req_d = 1'b1;
					st_d = pcs_pkg::S_WACT;
				end
			end
			pcs_pkg::S_WACT: begin
				if (rb.done) begin
					bvalid_d = 1'b1;
					bresp_d = rb.err ? pcs_pkg::RESP_SLVERR : pcs_pkg::RESP_OKAY;
					st_d = pcs_pkg::S_WRESP;
				end
			end
			pcs_pkg::S_WRESP: begin
				if (bready) begin
					bvalid_d = 1'b0;
					st_d = pcs_pkg::S_IDLE;
				end
			end
			pcs_pkg::S_RACT: begin
				if (rb.done) begin
					rvalid_d = 1'b1;
					rdata_d = rb.rdata;
					rresp_d = rb.err ? pcs_pkg::RESP_SLVERR : pcs_pkg::RESP_OKAY;
					st_d = pcs_pkg::S_RRESP;
				end
			end
			pcs_pkg::S_RRESP: begin
				if (rready) begin
					rvalid_d = 1'b0;
					st_d = pcs_pkg::S_IDLE;
				end
			end
			default: st_d = pcs_pkg::S_IDLE;
		endcase
		awready_d = (st_d == pcs_pkg::S_IDLE) && !aw_have_d;
		wready_d = (st_d == pcs_pkg::S_IDLE) && !w_have_d;
		arready_d = (st_d == pcs_pkg::S_IDLE) && !aw_have_d && !w_have_d;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= pcs_pkg::S_IDLE;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			waddr_q <= '0;
			addr_q <= '0;
			wbuf_q <= '0;
			strb_q <= '0;
			rb.wr_req <= 1'b0;
			rb.rd_req <= 1'b0;
			bvalid <= 1'b0;
			rvalid <= 1'b0;
			bresp <= pcs_pkg::RESP_OKAY;
			rresp <= pcs_pkg::RESP_OKAY;
			rdata <= '0;
			awready <= 1'b0;
			wready <= 1'b0;
			arready <= 1'b0;
		end else begin
			st_q <= st_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			waddr_q <= waddr_d;
			addr_q <= addr_d;
			wbuf_q <= wbuf_d;
			strb_q <= strb_d;
			rb.wr_req <= wr_req_d;
			rb.rd_req <= rd_req_d;
			bvalid <= bvalid_d;
			rvalid <= rvalid_d;
			bresp <= bresp_d;
			rresp <= rresp_d;
			rdata <= rdata_d;
			awready <= awready_d;
			wready <= wready_d;
			arready <= arready_d;
		end
	end

	assign rb.addr = addr_q;
	assign rb.wdata = wbuf_q;
	assign rb.strb = strb_q;
endmodule // axil_slave

// file: sim/data_mem_model.sv
`timescale 1ns/10ps
module data_mem_model (
	// clock
	input wire logic clock,
	// data memory port of the core
	input wire logic [pcs_pkg::DA_W-1:0] mem_addr,
	input wire logic mem_we,
	input wire logic mem_re,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] ram [0:511];
	initial begin
		// upper half differs from lower, so a stray bank bit shows up
		for (int i = 0; i < 512; i++) begin
			ram[i] = 8'(i ^ (i >> 1) ^ (i >> 8));
		end
	end
	// data valid only the cycle after a read strobe; toggles otherwise so stale data never matches
	always @(posedge clock) begin
		if (mem_we) begin
			ram[mem_addr] <= mem_wdata;
		end
		if (mem_re) begin
			mem_rdata <= ram[mem_addr];
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule // data_mem_model

// file: sim/program_counter_stack_indirect_test.sv
`timescale 1ns/10ps
module program_counter_stack_indirect_test;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic seq_step = 1'b0, seq_call = 1'b0, seq_goto = 1'b0, seq_int = 1'b0, seq_ret = 1'b0;
	logic [10:0] seq_target = 11'h000;
	logic [12:0] fetch_addr;
	logic [8:0] mem_addr;
	logic mem_we, mem_re;
	logic [7:0] mem_wdata, mem_rdata;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, s_rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int err_total = 0, num_checks = 0, we_n = 0, we_0;
	logic [12:0] pushed [0:9];
	logic [12:0] ret_to;
	always #50 clock = ~clock;
	always @(posedge clock) begin
		if (mem_we === 1'b1) we_n++;
	end
	pc_stack_core uut (.clock(clock), .sys_rst(sys_rst), .seq_step(seq_step),
		.seq_call(seq_call), .seq_goto(seq_goto), .seq_int(seq_int), .seq_ret(seq_ret),
		.seq_target(seq_target), .fetch_addr(fetch_addr), .mem_addr(mem_addr),
		.mem_we(mem_we), .mem_re(mem_re), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
		.s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
		.s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
		.s_arready(arready), .s_rdata(s_rdata), .s_rresp(rresp), .s_rvalid(rvalid),
		.s_rready(rready));
	data_mem_model dmem (.clock(clock), .mem_addr(mem_addr), .mem_we(mem_we),
		.mem_re(mem_re), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results();
		if (err_total == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// readies are registered, so the value at the falling edge is what the next rise samples
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_hit, w_hit, aw_pend, w_pend;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// valids settle only after this step, so pending halves are tracked locally
		aw_pend = 1'b1;
		w_pend = 1'b1;
		while (aw_pend || w_pend) begin
			@(negedge clock);
			aw_hit = aw_pend && awready === 1'b1;
			w_hit = w_pend && wready === 1'b1;
			@(posedge clock);
			if (aw_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
			aw_pend = aw_pend && !aw_hit;
			w_pend = w_pend && !w_hit;
		end
		do @(negedge clock); while (bvalid !== 1'b1);
		cmp("bresp", 32'(er), 32'(bresp));
		@(posedge clock);
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clock); while (arready !== 1'b1);
		@(posedge clock);
		arvalid <= 1'b0;
		do @(negedge clock); while (rvalid !== 1'b1);
		cmp("rresp", 32'(er), 32'(rresp));
		cmp("rdata", ed, s_rdata);
		@(posedge clock);
		rready <= 1'b0;
	endtask
	// v packs step, call, goto, int, ret; one-cycle event
	task automatic seq(input logic [4:0] v, input logic [10:0] t, input logic [12:0] exp);
		@(posedge clock);
		{seq_step, seq_call, seq_goto, seq_int, seq_ret} <= v;
		seq_target <= t;
		@(posedge clock);
		{seq_step, seq_call, seq_goto, seq_int, seq_ret} <= 5'h00;
		@(negedge clock);
		cmp("fetch_addr", 32'(exp), 32'(fetch_addr));
	endtask
	task automatic pc_is(input logic [12:0] exp);
		@(negedge clock);
		cmp("fetch_addr", 32'(exp), 32'(fetch_addr));
	endtask
	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		pc_is(13'h0000);
		axw(pcs_pkg::REG_LATCH, 32'h0000_001A, pcs_pkg::RESP_OKAY);
		axr(pcs_pkg::REG_LATCH, 32'h0000_001A, pcs_pkg::RESP_OKAY);
		axw(pcs_pkg::REG_PC_LOW, 32'hFFFF_FF37, pcs_pkg::RESP_OKAY);
		pc_is(13'h1A37);
		axr(pcs_pkg::REG_PC_LOW, 32'h0000_0037, pcs_pkg::RESP_OKAY);
		axw(pcs_pkg::REG_LATCH, 32'h0000_0008, pcs_pkg::RESP_OKAY);
		pushed[0] = 13'h1A37;
		for (int i = 1; i <= 9; i++) begin
			pushed[i] = {2'b01, 11'(i * 197)};
			seq(5'b01000, 11'(i * 197), pushed[i]);
		end
		axr(pcs_pkg::REG_LATCH, 32'h0000_0008, pcs_pkg::RESP_OKAY);
		// ninth push replaced the first, so pops run 8 down to 1
		for (int i = 8; i >= 1; i--) begin
			seq(5'b00001, 11'h000, pushed[i]);
		end
		seq(5'b00001, 11'h000, pushed[8]);
		axr(pcs_pkg::REG_LATCH, 32'h0000_0008, pcs_pkg::RESP_OKAY);
		ret_to = pushed[8] + 13'h0001;
		seq(5'b10000, 11'h000, ret_to);
		seq(5'b00010, 11'h000, pcs_pkg::IRQ_VEC);
		axw(pcs_pkg::REG_LATCH, 32'h0000_0010, pcs_pkg::RESP_OKAY);
		seq(5'b00100, 11'h2AB, 13'h12AB);
		seq(5'b10000, 11'h000, 13'h12AC);
		// goto must not have pushed, so this returns past the interrupt
		seq(5'b00001, 11'h000, ret_to);
		axw(pcs_pkg::REG_LATCH, 32'h0000_001F, pcs_pkg::RESP_OKAY);
		axw(pcs_pkg::REG_PC_LOW, 32'h0000_00FF, pcs_pkg::RESP_OKAY);
		pc_is(13'h1FFF);
		seq(5'b10000, 11'h000, 13'h0000);
		axw(pcs_pkg::REG_POINTER, 32'h0000_0025, pcs_pkg::RESP_OKAY);
		axw(pcs_pkg::REG_INDIRECT, 32'h0000_00A7, pcs_pkg::RESP_OKAY);
		axr(pcs_pkg::REG_INDIRECT, 32'h0000_00A7, pcs_pkg::RESP_OKAY);
		axr(pcs_pkg::REG_POINTER, 32'h0000_0025, pcs_pkg::RESP_OKAY);
		axw(pcs_pkg::REG_STATUS, 32'h0000_0080, pcs_pkg::RESP_OKAY);
		axr(pcs_pkg::REG_STATUS, 32'h0000_0080, pcs_pkg::RESP_OKAY);
		axr(pcs_pkg::REG_INDIRECT, 32'h0000_00A7, pcs_pkg::RESP_OKAY);
		axw(pcs_pkg::REG_POINTER, 32'h0000_0000, pcs_pkg::RESP_OKAY);
		axr(pcs_pkg::REG_INDIRECT, 32'h0000_0000, pcs_pkg::RESP_OKAY);
		we_0 = we_n;
		axw(pcs_pkg::REG_INDIRECT, 32'h0000_005C, pcs_pkg::RESP_OKAY);
		cmp("mem_we_count", 32'(we_0), 32'(we_n));
		axr(pcs_pkg::REG_POINTER, 32'h0000_0000, pcs_pkg::RESP_OKAY);
		axr(pcs_pkg::REG_LATCH, 32'h0000_001F, pcs_pkg::RESP_OKAY);
		axr(pcs_pkg::REG_PC_LOW, 32'h0000_0000, pcs_pkg::RESP_OKAY);
		// call and return on adjacent edges: the pop must see the entry just pushed
		@(posedge clock);
		seq_call <= 1'b1;
		seq_target <= 11'h155;
		@(posedge clock);
		seq_call <= 1'b0;
		seq_ret <= 1'b1;
		pc_is(13'h1955);
		@(posedge clock);
		seq_ret <= 1'b0;
		pc_is(13'h0000);
		axr(pcs_pkg::REG_INDIRECT, 32'h0000_0000, pcs_pkg::RESP_OKAY);
		axw(8'h14, 32'h0000_0099, pcs_pkg::RESP_SLVERR);
		axr(8'h14, 32'h0000_0000, pcs_pkg::RESP_SLVERR);
		results();
	end
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		results();
	end
endmodule // program_counter_stack_indirect_test
